//--- hw/ckb_pkg.sv
/*
  Constants for the clock bank output control block: register offsets,
  field positions, writable masks, reset values and driver type codes.
  Assumes a serial front end that presents byte-wide register accesses.
*/
package ckb_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned RATIO_W  = 9;
  localparam int unsigned PAIRS    = 4;
  localparam int unsigned TYPE_W   = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_DEV_CTRL0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DEV_CTRL1 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_A_TERM_POL = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_A_MODE_UP = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_A_MODE_LO = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_A_DIS     = 4'h5;

  // Field positions
  localparam int unsigned DIV_SYNC_BIT   = 0;
  localparam int unsigned A_SUPPLY_BIT   = 7;
  localparam int unsigned B_SUPPLY_BIT   = 6;
  localparam int unsigned A_GF_OFF_BIT   = 5;
  localparam int unsigned B_GF_OFF_BIT   = 4;
  localparam int unsigned A_PWR_OFF_BIT  = 3;
  localparam int unsigned B_PWR_OFF_BIT  = 2;
  localparam int unsigned A_DIV_OFF_BIT  = 1;
  localparam int unsigned B_DIV_OFF_BIT  = 0;
  localparam int unsigned TERM_BIT       = 4;
  localparam int unsigned POL_LSB        = 0;
  localparam int unsigned MODE_HI_LSB    = 3;
  localparam int unsigned MODE_LO_LSB    = 0;
  localparam int unsigned DIS_LSB        = 4;

  // Writable bits; reserved positions are stored as zero
  localparam logic [DATA_W-1:0] MASK_CTRL0 = 8'h01;
  localparam logic [DATA_W-1:0] MASK_CTRL1 = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_TP    = 8'h1F;
  localparam logic [DATA_W-1:0] MASK_MODE  = 8'h3F;
  localparam logic [DATA_W-1:0] MASK_DIS   = 8'hF0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CTRL0 = 8'h00;
  localparam logic [DATA_W-1:0] RST_CTRL1 = 8'h00;
  localparam logic [DATA_W-1:0] RST_TP    = 8'h00;
  localparam logic [DATA_W-1:0] RST_MODE  = 8'h12;
  localparam logic [DATA_W-1:0] RST_DIS   = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Driver type codes
  localparam logic [TYPE_W-1:0] DRV_HIZ    = 3'h0;
  localparam logic [TYPE_W-1:0] DRV_LVCMOS = 3'h3;

  // Divider
  localparam logic [RATIO_W-1:0] RATIO_ZERO = 9'h000;
  localparam logic [RATIO_W-1:0] RATIO_ONE  = 9'h001;
  localparam logic [RATIO_W-1:0] RATIO_MIN  = 9'h002;

endpackage : ckb_pkg

//--- hw/ckb_divider.sv
/*
  One bank output divider, run on the system clock as the reference.
  Assumes ratio is steady while the divider runs.
*/
`timescale 1ns/1ns
module ckb_divider (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        halt,
  input  wire logic                        bypass,
  input  wire logic [ckb_pkg::RATIO_W-1:0] ratio,
  output logic                             div_clk,
  output logic                             div_fall
);
  import ckb_pkg::*;

  logic [RATIO_W-1:0] cnt_r;
  logic [RATIO_W-1:0] cnt_nxt;
  logic               clk_r;
  logic               clk_nxt;
  logic               fall_r;
  logic               fall_nxt;
  wire  [RATIO_W-1:0] last_cnt = ratio - RATIO_ONE;
  wire  [RATIO_W-1:0] half_cnt = ratio >> 1;

  // Halt parks the count at zero so that two dividers leave it together
  assign cnt_nxt  = (halt || bypass || cnt_r == last_cnt) ? RATIO_ZERO : cnt_r + RATIO_ONE;
  assign clk_nxt  = halt ? 1'b0 : (bypass ? ~clk_r : (cnt_nxt < half_cnt));
  assign fall_nxt = clk_r & ~clk_nxt;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_r  <= RATIO_ZERO;
      clk_r  <= 1'b0;
      fall_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      clk_r  <= clk_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign div_clk  = clk_r;
  assign div_fall = fall_r;

endmodule : ckb_divider

//--- hw/ckb_bank.sv
/*
  Output enable and power state of one bank of four pairs.
  Assumes div_fall marks a falling edge of the bank clock and clk_static
  means the bank clock is held low.
*/
`timescale 1ns/1ns
module ckb_bank (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      glitchfree_off,
  input  wire logic                      power_off,
  input  wire logic [ckb_pkg::PAIRS-1:0] pair_off,
  input  wire logic [ckb_pkg::PAIRS-1:0] type_hiz,
  input  wire logic                      clk_static,
  input  wire logic                      div_fall,
  output logic      [ckb_pkg::PAIRS-1:0] pair_drive,
  output logic      [ckb_pkg::PAIRS-1:0] pair_powered
);
  import ckb_pkg::*;

  logic [PAIRS-1:0] drive_r;
  logic [PAIRS-1:0] drive_nxt;
  logic [PAIRS-1:0] powered_r;
  logic [PAIRS-1:0] powered_nxt;
  wire              bank_on = ~glitchfree_off & ~power_off;
  wire  [PAIRS-1:0] want    = {PAIRS{bank_on}} & ~pair_off & ~type_hiz & powered_r;
  // Enables move only while the bank clock is low, so no runt pulse leaves
  wire              update  = div_fall | clk_static;

  assign drive_nxt   = update ? want : drive_r;
  assign powered_nxt = {PAIRS{~power_off}} & ~pair_off;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      drive_r   <= '0;
      powered_r <= '0;
    end
    else
    begin
      drive_r   <= drive_nxt;
      powered_r <= powered_nxt;
    end
  end

  assign pair_drive   = drive_r;
  assign pair_powered = powered_r;

endmodule : ckb_bank

//--- hw/ckb_top.sv
/*
  Control registers of a two-bank clock fanout buffer, with the bank
  dividers, glitch-free enables, power state and Bank A pin behaviour.
  Assumes a serial front end on sys_clk giving byte register accesses,
  and divide ratios and Bank B pair disables from logic on sys_clk.
*/
`timescale 1ns/1ns

// Rules from the document
// [RULE_01] Sync bit set holds both dividers halted
// [RULE_02] Sync release restarts both dividers together
// [RULE_03] Per-bank supply hint: 0 means 3.3V
// [RULE_04] Bank A enable bit gates pairs glitch-free
// [RULE_05] Bank B enable bit gates pairs glitch-free
// [RULE_06] Bank A power-off bit unpowers all pairs
// [RULE_07] Bank B power-off bit unpowers all pairs
// [RULE_08] Host keeps enable off while powering up
// [RULE_09] Bank A divider off bit powers divider down
// [RULE_10] Bank B divider off bit powers divider down
// [RULE_11] Bypass needs ratio zero plus divider off; the code bypasses on ratio zero or one whatever the divider off bit
// [RULE_12] Reserved bits written zero, read undefined
// [RULE_13] Bank A registers at offsets two to five
// [RULE_14] LVCMOS polarity: 0 inverted, 1 in-phase
// [RULE_15] Pair disable 1 powers pair down
module ckb_top (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  input  wire logic [ckb_pkg::ADDR_W-1:0]         reg_addr,
  input  wire logic                               reg_wr_en,
  input  wire logic [ckb_pkg::DATA_W-1:0]         reg_wdata,
  input  wire logic                               reg_rd_en,
  output logic      [ckb_pkg::DATA_W-1:0]         reg_rdata,
  output logic                                    reg_rvalid,
  input  wire logic [ckb_pkg::RATIO_W-1:0]        bank_a_ratio,
  input  wire logic [ckb_pkg::RATIO_W-1:0]        bank_b_ratio,
  input  wire logic [ckb_pkg::PAIRS-1:0]          bank_b_pair_off,
  output logic                                    div_sync_active,
  output logic                                    bank_a_supply_hint,
  output logic                                    bank_b_supply_hint,
  output logic                                    bank_a_term_50,
  output logic [ckb_pkg::PAIRS*ckb_pkg::TYPE_W-1:0] bank_a_driver_type,
  output logic                                    bank_a_divider_power,
  output logic                                    bank_b_divider_power,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_a_drive,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_a_powered,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_a_clk_pos,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_a_clk_neg,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_b_drive,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_b_powered,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_b_clk_pos,
  output logic      [ckb_pkg::PAIRS-1:0]          bank_b_clk_neg
);
  import ckb_pkg::*;

  logic [DATA_W-1:0] ctrl0_r;
  logic [DATA_W-1:0] ctrl0_nxt;
  logic [DATA_W-1:0] ctrl1_r;
  logic [DATA_W-1:0] ctrl1_nxt;
  logic [DATA_W-1:0] a_tp_r;
  logic [DATA_W-1:0] a_tp_nxt;
  logic [DATA_W-1:0] a_mode_up_r;
  logic [DATA_W-1:0] a_mode_up_nxt;
  logic [DATA_W-1:0] a_mode_lo_r;
  logic [DATA_W-1:0] a_mode_lo_nxt;
  logic [DATA_W-1:0] a_dis_r;
  logic [DATA_W-1:0] a_dis_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              rvalid_r;

  // Address decode
  wire sel_ctrl0 = reg_addr == OFS_DEV_CTRL0;
  wire sel_ctrl1 = reg_addr == OFS_DEV_CTRL1;
  wire sel_tp    = reg_addr == OFS_A_TERM_POL; // [RULE_13]
  wire sel_up    = reg_addr == OFS_A_MODE_UP; // [RULE_13]
  wire sel_lo    = reg_addr == OFS_A_MODE_LO; // [RULE_13]
  wire sel_dis   = reg_addr == OFS_A_DIS; // [RULE_13]

  // Reserved positions are dropped on write and read back as zero
  assign ctrl0_nxt     = (reg_wr_en && sel_ctrl0) ? (reg_wdata & MASK_CTRL0) : ctrl0_r; // [RULE_12]
  assign ctrl1_nxt     = (reg_wr_en && sel_ctrl1) ? (reg_wdata & MASK_CTRL1) : ctrl1_r;
  assign a_tp_nxt      = (reg_wr_en && sel_tp) ? (reg_wdata & MASK_TP) : a_tp_r; // [RULE_12]
  assign a_mode_up_nxt = (reg_wr_en && sel_up) ? (reg_wdata & MASK_MODE) : a_mode_up_r; // [RULE_12]
  assign a_mode_lo_nxt = (reg_wr_en && sel_lo) ? (reg_wdata & MASK_MODE) : a_mode_lo_r; // [RULE_12]
  assign a_dis_nxt     = (reg_wr_en && sel_dis) ? (reg_wdata & MASK_DIS) : a_dis_r; // [RULE_12]

  // Unmapped offsets read as zero
  assign rdata_nxt = !reg_rd_en ? rdata_r :
                     sel_ctrl0  ? ctrl0_r :
                     sel_ctrl1  ? ctrl1_r :
                     sel_tp     ? a_tp_r :
                     sel_up     ? a_mode_up_r :
                     sel_lo     ? a_mode_lo_r :
                     sel_dis    ? a_dis_r : READ_ZERO;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl0_r     <= RST_CTRL0;
      ctrl1_r     <= RST_CTRL1;
      a_tp_r      <= RST_TP;
      a_mode_up_r <= RST_MODE;
      a_mode_lo_r <= RST_MODE;
      a_dis_r     <= RST_DIS;
      rdata_r     <= READ_ZERO;
      rvalid_r    <= 1'b0;
    end
    else
    begin
      ctrl0_r     <= ctrl0_nxt;
      ctrl1_r     <= ctrl1_nxt;
      a_tp_r      <= a_tp_nxt;
      a_mode_up_r <= a_mode_up_nxt;
      a_mode_lo_r <= a_mode_lo_nxt;
      a_dis_r     <= a_dis_nxt;
      rdata_r     <= rdata_nxt;
      rvalid_r    <= reg_rd_en;
    end
  end

  // Field extraction
  wire              div_sync             = ctrl0_r[DIV_SYNC_BIT];
  wire              bank_a_glitchfree_off = ctrl1_r[A_GF_OFF_BIT];
  wire              bank_b_glitchfree_off = ctrl1_r[B_GF_OFF_BIT];
  wire              bank_a_power_off     = ctrl1_r[A_PWR_OFF_BIT];
  wire              bank_b_power_off     = ctrl1_r[B_PWR_OFF_BIT];
  wire              bank_a_divider_off   = ctrl1_r[A_DIV_OFF_BIT];
  wire              bank_b_divider_off   = ctrl1_r[B_DIV_OFF_BIT];
  wire [PAIRS-1:0]  bank_a_pair_off      = a_dis_r[DIS_LSB +: PAIRS]; // [RULE_15]
  wire [PAIRS-1:0]  bank_a_pair_polarity = a_tp_r[POL_LSB +: PAIRS];
  wire [PAIRS*TYPE_W-1:0] types_a = {a_mode_up_r[MODE_HI_LSB +: TYPE_W],
                                     a_mode_up_r[MODE_LO_LSB +: TYPE_W],
                                     a_mode_lo_r[MODE_HI_LSB +: TYPE_W],
                                     a_mode_lo_r[MODE_LO_LSB +: TYPE_W]};

  // A ratio of zero or one cannot divide, so the divider toggles every cycle, at half the reference
  wire a_ratio_bypass = bank_a_ratio < RATIO_MIN; // [RULE_11]
  wire b_ratio_bypass = bank_b_ratio < RATIO_MIN; // [RULE_11]
  // A powered-down divider with a ratio of two or more has no clock to give
  wire a_halt = div_sync | (bank_a_divider_off & ~a_ratio_bypass); // [RULE_01] [RULE_09]
  wire b_halt = div_sync | (bank_b_divider_off & ~b_ratio_bypass); // [RULE_01] [RULE_10]

  logic a_div_clk;
  logic a_div_fall;
  logic b_div_clk;
  logic b_div_fall;

  // Both dividers share the one sync bit, so they leave halt on one edge
  ckb_divider u_div_a ( // [RULE_02]
    .sys_clk  (sys_clk),
    .rst      (rst),
    .halt     (a_halt),
    .bypass   (a_ratio_bypass),
    .ratio    (bank_a_ratio),
    .div_clk  (a_div_clk),
    .div_fall (a_div_fall)
  );

  ckb_divider u_div_b ( // [RULE_02]
    .sys_clk  (sys_clk),
    .rst      (rst),
    .halt     (b_halt),
    .bypass   (b_ratio_bypass),
    .ratio    (bank_b_ratio),
    .div_clk  (b_div_clk),
    .div_fall (b_div_fall)
  );

  logic [PAIRS-1:0] a_hiz;
  logic [PAIRS-1:0] a_drive;
  logic [PAIRS-1:0] a_powered;
  logic [PAIRS-1:0] b_drive;
  logic [PAIRS-1:0] b_powered;

  genvar gi;
  generate
    for (gi = 0; gi < PAIRS; gi = gi + 1)
    begin : g_type
      assign a_hiz[gi] = types_a[gi*TYPE_W +: TYPE_W] == DRV_HIZ;
    end
  endgenerate

  ckb_bank u_bank_a ( // [RULE_04] [RULE_06] [RULE_15]
    .sys_clk        (sys_clk),
    .rst            (rst),
    .glitchfree_off (bank_a_glitchfree_off),
    .power_off      (bank_a_power_off),
    .pair_off       (bank_a_pair_off),
    .type_hiz       (a_hiz),
    .clk_static     (a_halt),
    .div_fall       (a_div_fall),
    .pair_drive     (a_drive),
    .pair_powered   (a_powered)
  );

  ckb_bank u_bank_b ( // [RULE_05] [RULE_07]
    .sys_clk        (sys_clk),
    .rst            (rst),
    .glitchfree_off (bank_b_glitchfree_off),
    .power_off      (bank_b_power_off),
    .pair_off       (bank_b_pair_off),
    .type_hiz       ({PAIRS{1'b0}}),
    .clk_static     (b_halt),
    .div_fall       (b_div_fall),
    .pair_drive     (b_drive),
    .pair_powered   (b_powered)
  );

  // Pin levels; an undriven pair rests low
  logic [PAIRS-1:0] a_pos_r;
  logic [PAIRS-1:0] a_neg_r;
  logic [PAIRS-1:0] b_pos_r;
  logic [PAIRS-1:0] b_neg_r;
  logic [PAIRS-1:0] a_pos_nxt;
  logic [PAIRS-1:0] a_neg_nxt;
  logic [PAIRS-1:0] a_in_phase;

  generate
    for (gi = 0; gi < PAIRS; gi = gi + 1)
    begin : g_pol
      assign a_in_phase[gi] = (types_a[gi*TYPE_W +: TYPE_W] == DRV_LVCMOS)
                              & bank_a_pair_polarity[gi]; // [RULE_14]
    end
  endgenerate

  assign a_pos_nxt = a_drive & {PAIRS{a_div_clk}};
  assign a_neg_nxt = a_drive & (a_in_phase ~^ {PAIRS{a_div_clk}}); // [RULE_14]

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      a_pos_r <= '0;
      a_neg_r <= '0;
      b_pos_r <= '0;
      b_neg_r <= '0;
    end
    else
    begin
      a_pos_r <= a_pos_nxt;
      a_neg_r <= a_neg_nxt;
      b_pos_r <= b_drive & {PAIRS{b_div_clk}};
      b_neg_r <= b_drive & {PAIRS{~b_div_clk}};
    end
  end

  assign reg_rdata            = rdata_r;
  assign reg_rvalid           = rvalid_r;
  assign div_sync_active      = ctrl0_r[DIV_SYNC_BIT]; // [RULE_01]
  assign bank_a_supply_hint   = ctrl1_r[A_SUPPLY_BIT]; // [RULE_03]
  assign bank_b_supply_hint   = ctrl1_r[B_SUPPLY_BIT]; // [RULE_03]
  assign bank_a_term_50       = a_tp_r[TERM_BIT]; // [RULE_13]
  assign bank_a_driver_type   = types_a; // [RULE_13]
  assign bank_a_divider_power = ~ctrl1_r[A_DIV_OFF_BIT]; // [RULE_09]
  assign bank_b_divider_power = ~ctrl1_r[B_DIV_OFF_BIT]; // [RULE_10]
  assign bank_a_drive         = a_drive;
  assign bank_a_powered       = a_powered; // [RULE_06]
  assign bank_a_clk_pos       = a_pos_r;
  assign bank_a_clk_neg       = a_neg_r;
  assign bank_b_drive         = b_drive;
  assign bank_b_powered       = b_powered; // [RULE_07]
  assign bank_b_clk_pos       = b_pos_r;
  assign bank_b_clk_neg       = b_neg_r;

endmodule : ckb_top

//--- sim/ckb_top_monitor.sv
/*
  Port checker for ckb_top, attached by the bind at the foot of this file.
  Assumes bank ratios change only while the dividers are held by sync.
*/
`timescale 1ns/1ns
module ckb_top_monitor (
  input wire logic                                    sys_clk,
  input wire logic                                    rst,
  input wire logic [ckb_pkg::ADDR_W-1:0]              reg_addr,
  input wire logic                                    reg_wr_en,
  input wire logic [ckb_pkg::DATA_W-1:0]              reg_wdata,
  input wire logic                                    reg_rd_en,
  input wire logic [ckb_pkg::DATA_W-1:0]              reg_rdata,
  input wire logic                                    reg_rvalid,
  input wire logic [ckb_pkg::RATIO_W-1:0]             bank_a_ratio,
  input wire logic [ckb_pkg::RATIO_W-1:0]             bank_b_ratio,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_b_pair_off,
  input wire logic                                    div_sync_active,
  input wire logic                                    bank_a_supply_hint,
  input wire logic                                    bank_a_divider_power,
  input wire logic                                    bank_b_divider_power,
  input wire logic [ckb_pkg::PAIRS*ckb_pkg::TYPE_W-1:0] bank_a_driver_type,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_a_drive,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_a_powered,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_a_clk_pos,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_a_clk_neg,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_b_drive,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_b_powered,
  input wire logic [ckb_pkg::PAIRS-1:0]               bank_b_clk_pos
);
  import ckb_pkg::*;
  logic [3:0] pol_r;
  logic       algn_r;

  // Banks count as aligned only after a sync release with equal, steady settings
  always_ff @(posedge sys_clk)
  begin
    if (rst || bank_a_ratio != bank_b_ratio || !$stable(bank_a_ratio)
        || bank_a_divider_power != bank_b_divider_power
        || !$stable({bank_a_divider_power, bank_b_divider_power}))
      algn_r <= 1'b0;
    else if ($fell(div_sync_active))
      algn_r <= 1'b1;
    if (rst)
      pol_r <= 4'h0;
    else if (reg_wr_en && reg_addr == OFS_A_TERM_POL)
      pol_r <= reg_wdata[3:0];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  read_answer_a: assert property (reg_rd_en |=> reg_rvalid)
    else $error("Read not answered");
  unmapped_zero_a: assert property (reg_rd_en && reg_addr > OFS_A_DIS |=> reg_rdata == READ_ZERO)
    else $error("Unmapped read not zero");
  sync_field_a: assert property (reg_wr_en && reg_addr == OFS_DEV_CTRL0
    |=> div_sync_active == $past(reg_wdata[DIV_SYNC_BIT])) else $error("Sync bit wrong");
  sync_halt_a: assert property (div_sync_active [*3] |-> (bank_a_clk_pos | bank_b_clk_pos) == 4'h0)
    else $error("Clock runs under sync");
  bank_align_a: assert property (algn_r && bank_a_drive[0] && bank_b_drive[0]
    && $past(bank_a_drive[0]) && $past(bank_b_drive[0]) |-> bank_a_clk_pos[0] == bank_b_clk_pos[0])
    else $error("Banks not aligned");
  ctrl1_fields_a: assert property (reg_wr_en && reg_addr == OFS_DEV_CTRL1 |=>
    bank_a_supply_hint == $past(reg_wdata[A_SUPPLY_BIT])
    && bank_b_divider_power == !$past(reg_wdata[B_DIV_OFF_BIT])) else $error("Ctrl1 fields wrong");
  a_power_off_a: assert property (reg_wr_en && reg_addr == OFS_DEV_CTRL1
    && reg_wdata[A_PWR_OFF_BIT] |-> ##2 bank_a_powered == 4'h0) else $error("Bank A still powered");
  b_pair_off_a: assert property (bank_b_pair_off[0] [*3] |-> !bank_b_powered[0])
    else $error("Bank B pair still powered");
  a_polarity_a: assert property (bank_a_drive[0] && $past(bank_a_drive[0]) && $stable(pol_r)
    && $stable(bank_a_driver_type) |-> bank_a_clk_neg[0] == ((bank_a_driver_type[2:0] == DRV_LVCMOS
    && pol_r[0]) ? bank_a_clk_pos[0] : !bank_a_clk_pos[0])) else $error("Pair polarity wrong");
  a_hiz_low_a: assert property (!bank_a_drive[1] && !$past(bank_a_drive[1])
    |-> !bank_a_clk_pos[1] && !bank_a_clk_neg[1]) else $error("Undriven pair not low");
endmodule : ckb_top_monitor

bind ckb_top ckb_top_monitor u_ckb_top_monitor (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .bank_a_ratio(bank_a_ratio), .bank_b_ratio(bank_b_ratio), .bank_b_pair_off(bank_b_pair_off),
  .div_sync_active(div_sync_active), .bank_a_supply_hint(bank_a_supply_hint),
  .bank_a_divider_power(bank_a_divider_power), .bank_b_divider_power(bank_b_divider_power),
  .bank_a_driver_type(bank_a_driver_type), .bank_a_drive(bank_a_drive),
  .bank_a_powered(bank_a_powered), .bank_a_clk_pos(bank_a_clk_pos),
  .bank_a_clk_neg(bank_a_clk_neg), .bank_b_drive(bank_b_drive),
  .bank_b_powered(bank_b_powered), .bank_b_clk_pos(bank_b_clk_pos));

//--- sim/ckb_top_test.sv
/*
  Self-checking bench for ckb_top: register map, bank enables and power,
  divider timing and pin polarity against a register model.
  Assumes a 125 MHz sys_clk; inputs change at the falling edge.
*/
`timescale 1ns/1ns
module ckb_top_test;
  import ckb_pkg::*;
  logic        sys_clk, rst, reg_wr_en, reg_rd_en, reg_rvalid, div_sync_active;
  logic [3:0]  reg_addr, bank_b_pair_off, a_drv, a_pwr, a_pos, a_neg, b_drv, b_pwr, b_pos, b_neg;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [8:0]  bank_a_ratio, bank_b_ratio;
  logic        a_hint, b_hint, term, a_dpwr, b_dpwr;
  logic [11:0] types, typ;
  logic [7:0]  mdl [16];
  logic [7:0]  msk [16];
  logic [3:0]  pa, pb, ta;
  logic [31:0] seed;
  int          n_fail, checks, cyc, cnt;
  logic [8:0]  rt [6] = '{9'h005, 9'h003, 9'h002, 9'h000, 9'h001, 9'h005};
  logic        dv [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  int          hi [6] = '{12, 10, 15, 15, 15, 0};

  ckb_top u_ckb_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bank_a_ratio(bank_a_ratio), .bank_b_ratio(bank_b_ratio), .bank_b_pair_off(bank_b_pair_off),
    .div_sync_active(div_sync_active), .bank_a_supply_hint(a_hint), .bank_b_supply_hint(b_hint),
    .bank_a_term_50(term), .bank_a_driver_type(types), .bank_a_divider_power(a_dpwr),
    .bank_b_divider_power(b_dpwr), .bank_a_drive(a_drv), .bank_a_powered(a_pwr),
    .bank_a_clk_pos(a_pos), .bank_a_clk_neg(a_neg), .bank_b_drive(b_drv),
    .bank_b_powered(b_pwr), .bank_b_clk_pos(b_pos), .bank_b_clk_neg(b_neg));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // One idle cycle between accesses keeps each strobe a clean pulse
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    mdl[a] = d & msk[a];
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    chk("rvalid", 16'(reg_rvalid), 16'h0001);
    chk("rdata", 16'(reg_rdata), 16'(mdl[a]));
  endtask : rd

  task automatic fields;
    chk("sync", 16'(div_sync_active), 16'(mdl[0][DIV_SYNC_BIT]));
    chk("hints", 16'({a_hint, b_hint}), 16'(mdl[1][7:6]));
    chk("div_power", 16'({a_dpwr, b_dpwr}), {14'h0, ~mdl[1][1:0]});
    chk("term", 16'(term), 16'(mdl[2][TERM_BIT]));
    chk("types", 16'(types), 16'({mdl[3][5:0], mdl[4][5:0]}));
  endtask : fields

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cut a hang well above the few hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end

  initial
  begin
    rst = 1'b1;
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata, bank_b_pair_off} = '0;
    bank_a_ratio = 9'h004;
    bank_b_ratio = 9'h004;
    seed = 32'hB9434FE9;
    msk = '{0: MASK_CTRL0, 1: MASK_CTRL1, 2: MASK_TP, 3: MASK_MODE, 4: MASK_MODE, 5: MASK_DIS,
            default: 8'h00};
    mdl = '{3: 8'h12, 4: 8'h12, default: 8'h00};
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    fields;
    for (int i = 0; i < 16; i++) rd(4'(i));
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      wr(4'(i), seed[7:0]);
      fields;
    end
    for (int i = 0; i < 16; i++) rd(4'(i));
    wr(OFS_DEV_CTRL0, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      wr(OFS_DEV_CTRL1, seed[7:0] & 8'hFC);
      wr(OFS_A_DIS, seed[15:8]);
      wr(OFS_A_MODE_UP, seed[23:16] & 8'h36);
      wr(OFS_A_MODE_LO, seed[31:24] & 8'h36);
      bank_b_pair_off = seed[11:8];
      repeat (20) @(negedge sys_clk);
      typ = {mdl[3][5:0], mdl[4][5:0]};
      for (int p = 0; p < 4; p++) ta[p] = |typ[3*p +: 3];
      pa = mdl[1][A_PWR_OFF_BIT] ? 4'h0 : ~mdl[5][7:4];
      pb = mdl[1][B_PWR_OFF_BIT] ? 4'h0 : ~bank_b_pair_off;
      chk("a_powered", 16'(a_pwr), 16'(pa));
      chk("a_drive", 16'(a_drv), 16'(mdl[1][A_GF_OFF_BIT] ? 4'h0 : pa & ta));
      chk("b_powered", 16'(b_pwr), 16'(pb));
      chk("b_drive", 16'(b_drv), 16'(mdl[1][B_GF_OFF_BIT] ? 4'h0 : pb));
      fields;
    end
    wr(OFS_DEV_CTRL1, 8'h30);
    wr(OFS_A_TERM_POL, 8'h01);
    wr(OFS_A_MODE_LO, 8'h1B);
    wr(OFS_A_DIS, 8'h00);
    bank_b_pair_off = 4'h0;
    for (int e = 0; e < 6; e++)
    begin
      wr(OFS_DEV_CTRL0, 8'h01);
      repeat (3) @(negedge sys_clk);
      chk("halted", 16'(a_pos | b_pos), 16'h0000);
      bank_a_ratio = rt[e];
      bank_b_ratio = rt[e];
      wr(OFS_DEV_CTRL1, {6'h00, dv[e], dv[e]});
      wr(OFS_DEV_CTRL0, 8'h00);
      fields;
      repeat (8) @(negedge sys_clk);
      cnt = 0;
      repeat (30)
      begin
        @(negedge sys_clk);
        cnt += int'(a_pos[0]);
        chk("bank_align", 16'(a_pos[0]), 16'(b_pos[0]));
        chk("in_phase", 16'(a_neg[0]), 16'(a_pos[0]));
        chk("inverted", 16'(a_neg[1]), {15'h0, ~a_pos[1]});
        chk("b_inverted", 16'(b_neg[0]), {15'h0, ~b_pos[0]});
      end
      chk("high_count", 16'(cnt), 16'(hi[e]));
    end
    test_done;
  end
endmodule : ckb_top_test
